// [rtl/dtu_pkg.sv]
`default_nettype none
package dtu_pkg;

    // Interrupt sources and register port
    localparam int NUM_SRC = 8;
    localparam int SRC_W = 3;
    localparam int REG_AW = 2;
    localparam logic [1:0] OFS_ENABLE = 2'h0;
    localparam logic [1:0] OFS_SW_VECTOR = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [7:0] SW_VECTOR_RST = 8'h00;
    localparam int SWV_ENABLE_BIT = 7;

    // Vector table and descriptor layout
    localparam logic [23:0] VECTOR_BASE = 24'h000400;
    localparam logic [6:0] SRC_VECTOR_FIRST = 7'h10;
    localparam logic [7:0] RAM_PAGE = 8'hff;
    localparam logic [2:0] DESC_WORDS = 3'h6;
    localparam logic [23:0] DESC_BYTES = 24'h00000c;
    localparam logic [23:0] WORD_BYTES = 24'h000002;
    localparam logic [23:0] BYTE_STEP = 24'h000001;

    // Mode word A fields
    localparam int MRA_SM_HI = 7;
    localparam int MRA_DM_HI = 5;
    localparam int MRA_MD_HI = 3;
    localparam int MRA_DTS = 1;
    localparam int MRA_SZ = 0;
    localparam logic [1:0] MD_NORMAL = 2'h0;
    localparam logic [1:0] MD_REPEAT = 2'h1;
    localparam logic [1:0] MD_BLOCK = 2'h2;
    localparam logic [1:0] AM_INC = 2'h2;
    localparam logic [1:0] AM_DEC = 2'h3;

    // Mode word B fields
    localparam int MRB_CHAIN = 7;
    localparam int MRB_INTERRUPT_EVERY_TRANSFER_SELECT = 6;

    typedef enum logic [2:0] {
        ST_IDLE, ST_VECTOR, ST_FETCH, ST_READ, ST_WRITE, ST_BACK, ST_SETTLE
    } dtu_state_type;

    typedef struct packed {
        dtu_state_type st;
        logic [2:0] idx;
        logic sw_act;
        logic [SRC_W-1:0] src;
        logic [23:0] ptr;
        logic [7:0] mode_word_a;
        logic [23:0] source_address;
        logic [7:0] mode_word_b;
        logic [23:0] destination_address;
        logic [15:0] count_word_a;
        logic [15:0] count_word_b;
        logic [15:0] data;
        logic ended;
        logic [7:0] enable;
        logic [7:0] swv;
        logic [7:0] flag_clr;
        logic [7:0] cpu_irq;
        logic swdtend;
        logic sw_parked;
        logic [7:0] rdata;
        logic mem_req;
        logic mem_we;
        logic mem_byte;
        logic [23:0] mem_addr;
        logic [15:0] mem_wdata;
    } dtu_regs_type;

endpackage

`default_nettype wire

// [rtl/dtu_descriptor_transfer_unit.sv]
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Fetch descriptor, move data, write descriptor back
// - Chain enable continues with next descriptor
// - Normal, repeat and block modes per descriptor
// - 24-bit addresses step up, down or fixed
// - Normal: one unit, step 1/2, 65536 max
// - Repeat: reload counter and area address, continue
// - Block: whole block per request, area side selectable
// - Start on enabled interrupt or software vector write
// - Enable bit routes request to unit, else CPU
// - Clear flags only after last transfer ends
// - Software, no interrupt_every_transfer_select, count left: clear enable
// - Software, interrupt_every_transfer_select or exhausted: keep enable, interrupt
// - Interrupt, no interrupt_every_transfer_select, count left: clear flag
// - Interrupt, interrupt_every_transfer_select or exhausted: clear enable, forward
// - CPU masks and priorities never gate activation
// - Simultaneous sources served in fixed order
// - Software vector address is base plus vector shifted
// - Normal mode counts whole count word to zero
// - Repeat/block count low byte, reload from high
module dtu_descriptor_transfer_unit
    import dtu_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [REG_AW-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Interrupt sources and CPU side
    input wire logic [NUM_SRC-1:0] source_flag_in,
    output logic [NUM_SRC-1:0] source_flag_clear_out,
    output logic [NUM_SRC-1:0] cpu_irq_out,
    output logic sw_transfer_end_out,
    // Memory bus
    output logic mem_req_out,
    output logic mem_we_out,
    output logic mem_byte_out,
    output logic [23:0] mem_addr_out,
    output logic [15:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic [15:0] mem_rdata_in
);

    dtu_regs_type r_reg;
    dtu_regs_type r_next;

    logic [NUM_SRC-1:0] pending;
    logic any_pending;
    logic [SRC_W-1:0] first_src;

    // Requests routed by the enable bits; CPU priorities play no part
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_route
            assign pending[g] = source_flag_in[g] & r_reg.enable[g];
        end
    endgenerate

    assign any_pending = |pending;

    always_comb begin
        first_src = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                first_src = SRC_W'(i);
            end
        end
    end

    function automatic logic [23:0] step_addr(input logic [23:0] a, input logic [1:0] m,
                                               input logic sz);
        logic [23:0] d;
        d = sz ? WORD_BYTES : BYTE_STEP;
        case (m)
            AM_INC: step_addr = a + d;
            AM_DEC: step_addr = a - d;
            default: step_addr = a;
        endcase
    endfunction

    // Moves an area address back over one whole area length
    function automatic logic [23:0] rewind(input logic [23:0] a, input logic [1:0] m,
                                            input logic sz, input logic [7:0] len);
        logic [23:0] span;
        span = {15'h0000, len == 8'h00, len};
        if (sz) begin
            span = {span[22:0], 1'b0};
        end
        case (m)
            AM_INC: rewind = a - span;
            AM_DEC: rewind = a + span;
            default: rewind = a;
        endcase
    endfunction

    function automatic logic [15:0] desc_word(input dtu_regs_type s);
        case (s.idx)
            3'h0: desc_word = {s.mode_word_a, s.source_address[23:16]};
            3'h1: desc_word = s.source_address[15:0];
            3'h2: desc_word = {s.mode_word_b, s.destination_address[23:16]};
            3'h3: desc_word = s.destination_address[15:0];
            3'h4: desc_word = s.count_word_a;
            default: desc_word = s.count_word_b;
        endcase
    endfunction

    always_comb begin
        logic [1:0] md;
        logic [1:0] sm;
        logic [1:0] dm;
        logic sz;
        logic [7:0] low_next;
        logic [15:0] crb_dec;
        logic area_end;
        md = r_reg.mode_word_a[MRA_MD_HI -: 2];
        sm = r_reg.mode_word_a[MRA_SM_HI -: 2];
        dm = r_reg.mode_word_a[MRA_DM_HI -: 2];
        sz = r_reg.mode_word_a[MRA_SZ];
        low_next = r_reg.count_word_a[7:0] - 8'h01;
        crb_dec = r_reg.count_word_b - 16'h0001;
        area_end = 1'b0;
        r_next = r_reg;
        r_next.flag_clr = '0;
        r_next.swdtend = 1'b0;
        r_next.cpu_irq = source_flag_in & ~r_reg.enable;

        // Register port
        if (reg_write_in) begin
            case (reg_addr_in)
                OFS_ENABLE: r_next.enable = reg_wdata_in;
                OFS_SW_VECTOR: begin
                    if (!r_reg.swv[SWV_ENABLE_BIT]) begin
                        r_next.swv[6:0] = reg_wdata_in[6:0];
                        r_next.sw_parked = 1'b0;
                    end
                    if (reg_wdata_in[SWV_ENABLE_BIT]) begin
                        r_next.swv[SWV_ENABLE_BIT] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (reg_read_in) begin
            case (reg_addr_in)
                OFS_ENABLE: r_next.rdata = r_reg.enable;
                OFS_SW_VECTOR: r_next.rdata = r_reg.swv;
                OFS_STATUS: r_next.rdata = {r_reg.st != ST_IDLE, r_reg.sw_act, 3'h0, r_reg.src};
                default: r_next.rdata = 8'h00;
            endcase
        end

        // Bus cycle ends on acknowledge; next one issued afterwards
        if (r_reg.mem_req && mem_ack_in) begin
            r_next.mem_req = 1'b0;
        end

        case (r_reg.st)
            ST_IDLE: begin
                r_next.idx = '0;
                if (r_reg.swv[SWV_ENABLE_BIT] && !r_reg.sw_parked) begin
                    r_next.sw_act = 1'b1;
                    r_next.st = ST_VECTOR;
                    r_next.mem_addr = VECTOR_BASE + {16'h0000, r_reg.swv[6:0], 1'b0};
                end else if (any_pending) begin
                    r_next.sw_act = 1'b0;
                    r_next.src = first_src;
                    r_next.st = ST_VECTOR;
                    r_next.mem_addr = VECTOR_BASE
                        + {16'h0000, SRC_VECTOR_FIRST + 7'(first_src), 1'b0};
                end
                r_next.mem_req = r_next.st == ST_VECTOR;
                r_next.mem_we = 1'b0;
                r_next.mem_byte = 1'b0;
            end
            ST_VECTOR: begin
                if (r_reg.mem_req && mem_ack_in) begin
                    r_next.ptr = {RAM_PAGE, mem_rdata_in};
                    r_next.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (!r_reg.mem_req) begin
                    r_next.mem_req = 1'b1;
                    r_next.mem_we = 1'b0;
                    r_next.mem_byte = 1'b0;
                    r_next.mem_addr = r_reg.ptr + {20'h00000, r_reg.idx, 1'b0};
                end else if (mem_ack_in) begin
                    case (r_reg.idx)
                        3'h0: {r_next.mode_word_a, r_next.source_address[23:16]} = mem_rdata_in;
                        3'h1: r_next.source_address[15:0] = mem_rdata_in;
                        3'h2: {r_next.mode_word_b, r_next.destination_address[23:16]} = mem_rdata_in;
                        3'h3: r_next.destination_address[15:0] = mem_rdata_in;
                        3'h4: r_next.count_word_a = mem_rdata_in;
                        default: r_next.count_word_b = mem_rdata_in;
                    endcase
                    r_next.idx = r_reg.idx + 3'h1;
                    if (r_reg.idx == DESC_WORDS - 3'h1) begin
                        r_next.idx = '0;
                        r_next.st = ST_READ;
                    end
                end
            end
            ST_READ: begin
                if (!r_reg.mem_req) begin
                    r_next.mem_req = 1'b1;
                    r_next.mem_we = 1'b0;
                    r_next.mem_byte = !sz;
                    r_next.mem_addr = r_reg.source_address;
                end else if (mem_ack_in) begin
                    r_next.data = mem_rdata_in;
                    r_next.st = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (!r_reg.mem_req) begin
                    r_next.mem_req = 1'b1;
                    r_next.mem_we = 1'b1;
                    r_next.mem_byte = !sz;
                    r_next.mem_addr = r_reg.destination_address;
                    r_next.mem_wdata = r_reg.data;
                end else if (mem_ack_in) begin
                    r_next.source_address = step_addr(r_reg.source_address, sm, sz);
                    r_next.destination_address = step_addr(r_reg.destination_address, dm, sz);
                    r_next.st = ST_BACK;
                    r_next.ended = 1'b0;
                    case (md)
                        MD_REPEAT, MD_BLOCK: begin
                            r_next.count_word_a[7:0] = low_next;
                            if (low_next == 8'h00) begin
                                area_end = 1'b1;
                                r_next.count_word_a[7:0] = r_reg.count_word_a[15:8];
                            end
                            if (md == MD_BLOCK) begin
                                if (area_end) begin
                                    r_next.count_word_b = crb_dec;
                                    r_next.ended = crb_dec == 16'h0000;
                                end else begin
                                    r_next.st = ST_READ;
                                end
                            end
                        end
                        default: begin
                            r_next.count_word_a = r_reg.count_word_a - 16'h0001;
                            r_next.ended = r_next.count_word_a == 16'h0000;
                        end
                    endcase
                    if (area_end) begin
                        if (r_reg.mode_word_a[MRA_DTS]) begin
                            r_next.source_address = rewind(r_next.source_address, sm, sz, r_reg.count_word_a[15:8]);
                        end else begin
                            r_next.destination_address = rewind(r_next.destination_address, dm, sz, r_reg.count_word_a[15:8]);
                        end
                    end
                end
            end
            ST_BACK: begin
                if (!r_reg.mem_req) begin
                    r_next.mem_req = 1'b1;
                    r_next.mem_we = 1'b1;
                    r_next.mem_byte = 1'b0;
                    r_next.mem_addr = r_reg.ptr + {20'h00000, r_reg.idx, 1'b0};
                    r_next.mem_wdata = desc_word(r_reg);
                end else if (mem_ack_in) begin
                    r_next.idx = r_reg.idx + 3'h1;
                    if (r_reg.idx == DESC_WORDS - 3'h1) begin
                        r_next.idx = '0;
                        if (r_reg.mode_word_b[MRB_CHAIN]) begin
                            r_next.ptr = r_reg.ptr + DESC_BYTES;
                            r_next.st = ST_FETCH;
                        end else begin
                            r_next.st = ST_SETTLE;
                            if (r_reg.sw_act) begin
                                if (!r_reg.mode_word_b[MRB_INTERRUPT_EVERY_TRANSFER_SELECT] && !r_reg.ended) begin
                                    r_next.swv[SWV_ENABLE_BIT] = 1'b0;
                                end else begin
                                    r_next.swdtend = 1'b1;
                                    // Enable stays set, so no endless restart
                                    r_next.sw_parked = 1'b1;
                                end
                            end else if (!r_reg.mode_word_b[MRB_INTERRUPT_EVERY_TRANSFER_SELECT] && !r_reg.ended) begin
                                r_next.flag_clr[r_reg.src] = 1'b1;
                            end else begin
                                r_next.enable[r_reg.src] = 1'b0;
                            end
                        end
                    end
                end
            end
            ST_SETTLE: begin
                // Gives the source one cycle to drop its flag
                r_next.st = ST_IDLE;
            end
            default: r_next.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.enable <= ENABLE_RST;
            r_reg.swv <= SW_VECTOR_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata_out = r_reg.rdata;
    assign source_flag_clear_out = r_reg.flag_clr;
    assign cpu_irq_out = r_reg.cpu_irq;
    assign sw_transfer_end_out = r_reg.swdtend;
    assign mem_req_out = r_reg.mem_req;
    assign mem_we_out = r_reg.mem_we;
    assign mem_byte_out = r_reg.mem_byte;
    assign mem_addr_out = r_reg.mem_addr;
    assign mem_wdata_out = r_reg.mem_wdata;

endmodule // dtu_descriptor_transfer_unit

`default_nettype wire

// [testbench/dtu_bus_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module dtu_bus_monitor
    import dtu_pkg::*;
(
    // Clock, reset and register port
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic [REG_AW-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // Sources and CPU side
    input wire logic [NUM_SRC-1:0] source_flag_in,
    input wire logic [NUM_SRC-1:0] source_flag_clear_out,
    input wire logic [NUM_SRC-1:0] cpu_irq_out,
    input wire logic sw_transfer_end_out,
    // Memory bus
    input wire logic mem_req_out,
    input wire logic mem_we_out,
    input wire logic mem_byte_out,
    input wire logic [23:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic mem_ack_in
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    a_req_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out &&
        $stable({mem_we_out, mem_byte_out, mem_addr_out, mem_wdata_out}))
        else $error("memory request changed before ack");
    a_req_gap: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
        else $error("no idle cycle after ack");
    a_cpu_forward: assert property ((cpu_irq_out & ~$past(source_flag_in)) == 8'h00)
        else $error("cpu request without source flag");
    a_clear_pulse: assert property (source_flag_clear_out != 8'h00 |->
        $onehot(source_flag_clear_out) ##1 source_flag_clear_out == 8'h00)
        else $error("flag clear not a single pulse");
    a_swend_pulse: assert property (sw_transfer_end_out |=> !sw_transfer_end_out)
        else $error("transfer end pulse too long");
    a_end_after_wb: assert property (source_flag_clear_out != 8'h00 || sw_transfer_end_out
        |-> $past(mem_ack_in) && $past(mem_we_out))
        else $error("end action not after write-back");
    a_busy_status: assert property (reg_read_in && reg_addr_in == OFS_STATUS && mem_req_out
        |=> reg_rdata_out[7])
        else $error("status not busy during transfer");
    a_sw_start: assert property (reg_write_in && reg_addr_in == OFS_SW_VECTOR &&
        reg_wdata_in[7] && !mem_req_out && !$past(mem_req_out) |-> ##[1:6] mem_req_out)
        else $error("software start missing");
endmodule // dtu_bus_monitor

bind dtu_descriptor_transfer_unit dtu_bus_monitor u_mon (.clock_in(clock_in),
    .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .source_flag_in(source_flag_in), .source_flag_clear_out(source_flag_clear_out),
    .cpu_irq_out(cpu_irq_out), .sw_transfer_end_out(sw_transfer_end_out),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_byte_out(mem_byte_out),
    .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in));
`default_nettype wire

// [testbench/dtu_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dtu_mem_model (
    // Clock and pace
    input wire logic clock_in,
    input wire logic slow_in,
    // Memory bus from the unit
    input wire logic req_in,
    input wire logic we_in,
    input wire logic byte_in,
    input wire logic [23:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic ack_out,
    output logic [15:0] rdata_out
);
    logic [15:0] words [logic [22:0]];
    logic [1:0] wait_cnt = 2'h0;
    logic [15:0] cur;
    initial ack_out = 1'b0;
    initial rdata_out = 16'h5555;
    // Bytes at even addresses sit in the high half; idle data toggles
    always @(posedge clock_in) begin
        cur = words.exists(addr_in[23:1]) ? words[addr_in[23:1]] : 16'h3c3c;
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out) begin
            if (wait_cnt != (slow_in ? 2'h3 : 2'h0)) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else begin
                ack_out <= 1'b1;
                wait_cnt <= 2'h0;
                if (we_in && !byte_in) words[addr_in[23:1]] = wdata_in;
                else if (we_in) words[addr_in[23:1]] = addr_in[0] ?
                    {cur[15:8], wdata_in[7:0]} : {wdata_in[7:0], cur[7:0]};
                else if (!byte_in) rdata_out <= cur;
                else rdata_out <= {8'h00, addr_in[0] ? cur[7:0] : cur[15:8]};
            end
        end
    end
endmodule // dtu_mem_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dtu_pkg::*;
    logic clock_in, nrst_in, reg_write, reg_read, slow, irq2_before, swend;
    logic mem_req, mem_we, mem_byte, mem_ack;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, flags, clr_out, irq_out, clr_seen, got;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata;
    int err_count = 0, total_checks = 0, cycles = 0, swend_cnt = 0, i;

    dtu_descriptor_transfer_unit DUT (.clock_in(clock_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
        .reg_read_in(reg_read), .reg_rdata_out(reg_rdata), .source_flag_in(flags),
        .source_flag_clear_out(clr_out), .cpu_irq_out(irq_out), .sw_transfer_end_out(swend),
        .mem_req_out(mem_req), .mem_we_out(mem_we), .mem_byte_out(mem_byte),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_ack_in(mem_ack),
        .mem_rdata_in(mem_rdata));
    dtu_mem_model u_mem (.clock_in(clock_in), .slow_in(slow), .req_in(mem_req), .we_in(mem_we),
        .byte_in(mem_byte), .addr_in(mem_addr), .wdata_in(mem_wdata), .ack_out(mem_ack),
        .rdata_out(mem_rdata));

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    // Peripheral side: flags drop on a clear pulse; watchdog
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (clr_out != 8'h00) begin
            clr_seen <= clr_seen | clr_out;
            flags <= flags & ~clr_out;
        end
        if (clr_out[1]) irq2_before <= irq_out[2];
        if (swend) swend_cnt <= swend_cnt + 1;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_mem(input string n, input logic [23:0] a, input logic [15:0] e);
        total_checks++;
        if (u_mem.words[a[23:1]] !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, u_mem.words[a[23:1]]);
        end
    endtask

    task automatic do_reset;
        nrst_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock_in);
        reg_write <= 1'b0;
        @(posedge clock_in);
    endtask

    task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock_in);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clock_in);
    endtask

    task automatic put(input logic [23:0] a, input logic [15:0] w);
        u_mem.words[a[23:1]] = w;
    endtask

    task automatic put_desc(input logic [23:0] p, input logic [7:0] ma, input logic [23:0] s,
        input logic [7:0] mb, input logic [23:0] d, input logic [15:0] ca, input logic [15:0] cb);
        put(p, {ma, s[23:16]});
        put(p + 24'h2, s[15:0]);
        put(p + 24'h4, {mb, d[23:16]});
        put(p + 24'h6, d[15:0]);
        put(p + 24'h8, ca);
        put(p + 24'ha, cb);
    endtask

    task automatic wait_idle;
        int low;
        low = 0;
        while (low < 6) begin
            @(posedge clock_in);
            low = mem_req ? 0 : low + 1;
        end
    endtask

    initial begin
        {nrst_in, reg_write, reg_read, slow, irq2_before} = 5'h00;
        {reg_addr, reg_wdata, flags, clr_seen} = 26'h0;
        do_reset();
        reg_rd(OFS_ENABLE, got);
        chk_reg("enable reset", ENABLE_RST, got);
        reg_rd(2'h3, got);
        chk_reg("unmapped", 8'h00, got);
        // Software start, normal word transfer with count left
        put(24'h000460, 16'h0000);
        put_desc(24'hff0000, 8'ha1, 24'hff1000, 8'h00, 24'hff2000, 16'h0002, 16'h0000);
        put(24'hff1000, 16'hbeef);
        put(24'hff1002, 16'h1234);
        reg_wr(OFS_SW_VECTOR, 8'hb0);
        wait_idle();
        chk_mem("first word", 24'hff2000, 16'hbeef);
        chk_mem("source back", 24'hff0002, 16'h1002);
        chk_mem("dest back", 24'hff0006, 16'h2002);
        chk_mem("count back", 24'hff0008, 16'h0001);
        reg_rd(OFS_SW_VECTOR, got);
        chk_reg("vector after", 8'h30, got);
        // Second start runs the count out
        reg_wr(OFS_SW_VECTOR, 8'hb0);
        for (i = 0; i < 2000 && swend_cnt == 0; i++) @(posedge clock_in);
        wait_idle();
        reg_rd(OFS_SW_VECTOR, got);
        chk_reg("vector kept", 8'hb0, got);
        chk_reg("end pulses", 8'h01, swend_cnt[7:0]);
        chk_mem("second word", 24'hff2002, 16'h1234);
        do_reset();
        // Two sources at once, slow memory, block then chained repeat
        slow <= 1'b1;
        put(24'h000422, 16'h0100);
        put(24'h000424, 16'h0200);
        put_desc(24'hff0100, 8'ha8, 24'hff1100, 8'h80, 24'hff2100, 16'h0202, 16'h0003);
        put_desc(24'hff010c, 8'h24, 24'hff1200, 8'h00, 24'hff2200, 16'h0202, 16'h0000);
        put_desc(24'hff0200, 8'ha0, 24'hff1300, 8'h00, 24'hff2300, 16'h0001, 16'h0000);
        put(24'hff1100, 16'h5a6b);
        put(24'hff1200, 16'h7c11);
        put(24'hff1300, 16'h9d22);
        put(24'hff2200, 16'h0000);
        put(24'hff2300, 16'h0000);
        reg_wr(OFS_ENABLE, 8'h06);
        flags <= 8'h26;
        repeat (3) @(posedge clock_in);
        reg_rd(OFS_STATUS, got);
        chk_reg("status busy", 8'h81, got);
        wait_idle();
        chk_mem("block data", 24'hff2100, 16'h5a6b);
        chk_mem("block dest", 24'hff0106, 16'h2100);
        chk_mem("block count", 24'hff010a, 16'h0002);
        chk_mem("block size", 24'hff0108, 16'h0202);
        chk_mem("chain data", 24'hff2200, 16'h7c00);
        chk_mem("repeat count", 24'hff0114, 16'h0201);
        chk_mem("normal data", 24'hff2300, 16'h9d00);
        chk_reg("flags cleared", 8'h02, clr_seen);
        chk_reg("service order", 8'h00, {7'h00, irq2_before});
        chk_reg("cpu requests", 8'h24, irq_out);
        reg_rd(OFS_ENABLE, got);
        chk_reg("enable after", 8'h02, got);
        // Software start: repeat word, source area, decrementing source, interrupt_every_transfer_select set
        put(24'h000462, 16'h0300);
        put_desc(24'hff0300, 8'hc7, 24'hff1402, 8'h40, 24'hff2400, 16'h0101, 16'h0000);
        put(24'hff1402, 16'hc0de);
        reg_wr(OFS_SW_VECTOR, 8'hb1);
        wait_idle();
        chk_mem("repeat word", 24'hff2400, 16'hc0de);
        chk_mem("area restored", 24'hff0302, 16'h1402);
        chk_mem("repeat reload", 24'hff0308, 16'h0101);
        reg_rd(OFS_SW_VECTOR, got);
        chk_reg("interrupt_every_transfer_select kept", 8'hb1, got);
        chk_reg("interrupt_every_transfer_select pulse", 8'h02, swend_cnt[7:0]);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
